// File: pkg/sgp_pkg.sv
// sgp_pkg: constants for the six-pin gpio port
// assumes: core drives register strobes on the instruction clock
package sgp_pkg;
    localparam int          SGP_PINS        = 6;
    localparam int          SGP_REG_W       = 8;
    localparam int          SGP_IN_ONLY_BIT = 3;
    localparam int          SGP_TMR_BIT     = 2;
    localparam logic [5:0]  SGP_DIR_RESET   = 6'h3F;
    localparam logic [5:0]  SGP_PULL_MASK   = 6'h0B;
    localparam logic [5:0]  SGP_LATCH_POR   = 6'h00;
    localparam logic [1:0]  SGP_UPPER_ZERO  = 2'h0;
endpackage

// File: rtl/sgp_port.sv
// sgp_port: six-pin gpio port with port and direction registers
// assumes: core issues one-cycle strobes; clk_i is the instruction clock
//
// How it works
// RULE_01: port read returns sampled pin levels
// RULE_02: upper two port bits read zero
// RULE_03: pin 3 is input only, never driven
// RULE_04: alternate-function pins read as zero
// RULE_05: pull-up and wake only pins 0,1,3
// RULE_06: master clear forces pull-up, no wake
// RULE_07: direction loaded from working reg, write-only
// RULE_08: direction one tristates, zero drives latch
// RULE_09: any reset sets all direction bits
// RULE_10: timer clock select overrides direction on pin
// RULE_11: outputs latched, inputs sampled at read
// RULE_12: bit set/clear rewrite all latches from pins
// RULE_13: write lands end of cycle, read at start
// RULE_14: latches cleared on power-on, kept otherwise
// RULE_15: outside holds inputs until sampled
// RULE_16: outside never fights a driven pin
// RULE_17: pull-up and wake enables are active low
`timescale 1ns/1ps
module sgp_port (
    // clock and resets
    input  wire logic                            clk_i,
    input  wire logic                            srst_i,
    input  wire logic                            por_i,
    // register side
    input  wire logic                            port_wr_i,
    input  wire logic [sgp_pkg::SGP_REG_W-1:0]   port_wdata_i,
    input  wire logic                            port_rd_i,
    input  wire logic                            bit_set_instr_i,
    input  wire logic                            bit_clear_instr_i,
    input  wire logic [2:0]                      bit_sel_i,
    input  wire logic                            dir_load_i,
    input  wire logic [sgp_pkg::SGP_REG_W-1:0]   work_reg_i,
    output logic      [sgp_pkg::SGP_REG_W-1:0]   port_rdata_o,
    // configuration
    input  wire logic [sgp_pkg::SGP_PINS-1:0]    alt_func_i,
    input  wire logic                            master_clear_enable_i,
    input  wire logic                            timer_clock_source_sel_i,
    input  wire logic                            pullup_en_n_i,
    input  wire logic                            wake_en_n_i,
    // pins
    input  wire logic [sgp_pkg::SGP_PINS-1:0]    port_pins_i,
    output logic      [sgp_pkg::SGP_PINS-1:0]    port_pins_o,
    output logic      [sgp_pkg::SGP_PINS-1:0]    port_pins_oe_o,
    output logic      [sgp_pkg::SGP_PINS-1:0]    pullup_on_o,
    output logic                                 wake_o
);
    import sgp_pkg::*;

    logic [SGP_PINS-1:0] pins_sync;
    logic [SGP_PINS-1:0] pins_prev_ff;
    logic [SGP_PINS-1:0] latch_ff;
    logic [SGP_PINS-1:0] dir_ff;
    logic [SGP_PINS-1:0] read_val;
    logic [SGP_PINS-1:0] nxt_latch;
    logic [SGP_PINS-1:0] wake_mask;
    logic [SGP_PINS-1:0] oe_mask;

    sgp_sync #(.W(SGP_PINS)) u_sync (
        .clk_i (clk_i),
        .d_i   (port_pins_i),
        .q_o   (pins_sync)
    );

    // ----------------------------------------
    // read path
    // ----------------------------------------
    // pin levels seen at start of the cycle, whatever the direction
    assign read_val = pins_sync & ~alt_func_i; // see RULE_01 see RULE_04 see RULE_11

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            port_rdata_o <= {SGP_UPPER_ZERO, SGP_LATCH_POR};
        end else if (port_rd_i) begin
            port_rdata_o <= {SGP_UPPER_ZERO, read_val}; // see RULE_02 see RULE_13
        end
    end

    // ----------------------------------------
    // output latches
    // ----------------------------------------
    // read-modify-write uses pin levels, so input pins' latches get clobbered
    always_comb begin
        nxt_latch = latch_ff;
        if (port_wr_i) begin
            nxt_latch = port_wdata_i[SGP_PINS-1:0];
        end else if (bit_set_instr_i || bit_clear_instr_i) begin
            nxt_latch = read_val; // see RULE_12
            if (bit_sel_i < 3'(SGP_PINS)) begin
                nxt_latch[bit_sel_i] = bit_set_instr_i;
            end
        end
    end

    // por clears; plain reset leaves latches alone
    always_ff @(posedge clk_i) begin
        if (por_i) begin
            latch_ff <= SGP_LATCH_POR; // see RULE_14
        end else begin
            latch_ff <= nxt_latch; // see RULE_11 see RULE_13
        end
    end

    // ----------------------------------------
    // direction register
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i || por_i) begin
            dir_ff <= SGP_DIR_RESET; // see RULE_09
        end else if (dir_load_i) begin
            dir_ff <= work_reg_i[SGP_PINS-1:0]; // see RULE_07
        end
    end

    // ----------------------------------------
    // drivers, pull-ups, wake
    // ----------------------------------------
    always_comb begin
        oe_mask = ~dir_ff & ~alt_func_i; // see RULE_08
        oe_mask[SGP_IN_ONLY_BIT] = 1'b0; // see RULE_03
        if (timer_clock_source_sel_i) begin
            oe_mask[SGP_TMR_BIT] = 1'b0; // see RULE_10
        end
    end

    assign port_pins_oe_o = oe_mask;
    assign port_pins_o    = latch_ff & oe_mask;

    always_comb begin
        pullup_on_o = pullup_en_n_i ? '0 : SGP_PULL_MASK; // see RULE_05 see RULE_17
        wake_mask   = wake_en_n_i ? '0 : SGP_PULL_MASK;
        if (master_clear_enable_i) begin
            pullup_on_o[SGP_IN_ONLY_BIT] = 1'b1; // see RULE_06
            wake_mask[SGP_IN_ONLY_BIT]   = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            // follow the pins in reset so release raises no false wake
            pins_prev_ff <= pins_sync;
            wake_o       <= 1'b0;
        end else begin
            pins_prev_ff <= pins_sync;
            wake_o       <= |((pins_sync ^ pins_prev_ff) & wake_mask); // see RULE_05
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_upper_zero: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE_02
        port_rdata_o[SGP_REG_W-1:SGP_PINS] == SGP_UPPER_ZERO)
        else $error("upper port bits nonzero");
    chk_in_only: assert property (@(posedge clk_i) // see RULE_03
        !port_pins_oe_o[SGP_IN_ONLY_BIT])
        else $error("input-only pin driven");
    chk_read_pins: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE_01
        port_rd_i |=> port_rdata_o[SGP_PINS-1:0] == $past(read_val))
        else $error("port read mismatch");
    chk_dir_reset: assert property (@(posedge clk_i) // see RULE_09
        srst_i |=> dir_ff == SGP_DIR_RESET)
        else $error("direction not reset");
    chk_dir_load: assert property (@(posedge clk_i) disable iff (srst_i || por_i) // see RULE_07
        dir_load_i |=> dir_ff == $past(work_reg_i[SGP_PINS-1:0]))
        else $error("direction load failed");
    chk_oe_dir: assert property (@(posedge clk_i) disable iff (srst_i || por_i) // see RULE_08
        (port_pins_oe_o & dir_ff) == '0)
        else $error("input pin driven");
    chk_tmr_override: assert property (@(posedge clk_i) // see RULE_10
        timer_clock_source_sel_i |-> !port_pins_oe_o[SGP_TMR_BIT])
        else $error("timer pin driven");
    chk_master_clear_input_pull: assert property (@(posedge clk_i) // see RULE_06
        master_clear_enable_i |-> pullup_on_o[SGP_IN_ONLY_BIT])
        else $error("master_clear_input pull-up off");
    chk_pull_pins: assert property (@(posedge clk_i) // see RULE_05
        (pullup_on_o & ~SGP_PULL_MASK) == '0)
        else $error("pull-up on wrong pin");
    chk_latch_hold: assert property (@(posedge clk_i) disable iff (por_i) // see RULE_11
        !(port_wr_i || bit_set_instr_i || bit_clear_instr_i) |=> $stable(latch_ff))
        else $error("latch changed unwritten");
    chk_alt_read: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE_04
        port_rd_i |=> (port_rdata_o[SGP_PINS-1:0] & $past(alt_func_i)) == '0)
        else $error("alternate pin read nonzero");
    chk_alt_drv: assert property (@(posedge clk_i) // see RULE_04
        (port_pins_oe_o & alt_func_i) == '0)
        else $error("alternate pin driven");
    chk_drive_out: assert property (@(posedge clk_i) disable iff (srst_i || por_i) // see RULE_08
        !timer_clock_source_sel_i |->
            (~dir_ff & ~alt_func_i & ~port_pins_oe_o & ~(SGP_PINS'(1) << SGP_IN_ONLY_BIT)) == '0)
        else $error("output pin not driven");
    chk_pin_value: assert property (@(posedge clk_i) disable iff (por_i) // see RULE_08
        ((port_pins_o ^ latch_ff) & port_pins_oe_o) == '0)
        else $error("driven pin differs from latch");
    chk_wake_pins: assert property (@(posedge clk_i) // see RULE_05
        (wake_mask & ~SGP_PULL_MASK) == '0)
        else $error("wake on wrong pin");
    chk_master_clear_input_wake: assert property (@(posedge clk_i) // see RULE_06
        master_clear_enable_i |-> !wake_mask[SGP_IN_ONLY_BIT])
        else $error("wake on master clear pin");
    chk_pull_off: assert property (@(posedge clk_i) // see RULE_17
        pullup_en_n_i && !master_clear_enable_i |-> pullup_on_o == '0)
        else $error("pull-up on while disabled");
    chk_wake_off: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE_17
        wake_en_n_i |=> !wake_o)
        else $error("wake while disabled");
    chk_latch_por: assert property (@(posedge clk_i) // see RULE_14
        por_i |=> latch_ff == SGP_LATCH_POR)
        else $error("latch not cleared by por");

    // rmw: latches take the pin levels, only the selected bit may differ
    sequence s_rmw_take;
        (bit_set_instr_i || bit_clear_instr_i) && !port_wr_i;
    endsequence
    sequence s_latch_from_pins;
        $countones(latch_ff ^ $past(read_val)) <= 1;
    endsequence

    chk_rmw_pins: assert property (@(posedge clk_i) disable iff (por_i) // see RULE_12
        s_rmw_take |=> s_latch_from_pins)
        else $error("rmw latch not from pins");
    chk_bit_set: assert property (@(posedge clk_i) disable iff (por_i) // see RULE_12
        bit_set_instr_i && !port_wr_i && (bit_sel_i < 3'(SGP_PINS))
        |=> latch_ff[$past(bit_sel_i)])
        else $error("bit set failed");
    chk_bit_clear: assert property (@(posedge clk_i) disable iff (por_i) // see RULE_12
        bit_clear_instr_i && !bit_set_instr_i && !port_wr_i && (bit_sel_i < 3'(SGP_PINS))
        |=> !latch_ff[$past(bit_sel_i)])
        else $error("bit clear failed");
    chk_write_lands: assert property (@(posedge clk_i) disable iff (por_i) // see RULE_13
        port_wr_i |=> latch_ff == $past(port_wdata_i[SGP_PINS-1:0]))
        else $error("port write lost");
endmodule

// File: rtl/sgp_sync.sv
// sgp_sync: two-flop synchroniser for the pin levels
// assumes: pins are asynchronous to clk_i
`timescale 1ns/1ps
module sgp_sync #(
    parameter int W = 6
) (
    // clock
    input  wire logic         clk_i,
    // data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clk_i) begin
        meta_ff <= d_i;
        q_o     <= meta_ff;
    end
endmodule

// File: tb/sgp_pins_model.sv
// sgp_pins_model: outside circuitry on the six port pins
// assumes: the bench holds ext_i steady until the port has read it
`timescale 1ns/1ps
module sgp_pins_model (
    // port side
    input  wire logic [5:0] oe_i,
    input  wire logic [5:0] drv_i,
    // outside side
    input  wire logic [5:0] ext_i,
    output logic      [5:0] level_o
);
    // outside drives only pins the port leaves undriven, no wired logic
    assign level_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule

// File: tb/tb.sv
// tb: self-checking bench for the six-pin gpio port
// assumes: sgp_pins_model closes the loop from port outputs to pin inputs
`timescale 1ns/1ps
module tb;
    import sgp_pkg::*;
    logic       clk_i = 0, srst_i = 1, por_i = 1, wr = 0, rd = 0;
    logic       dld = 0, bset = 0, bclr = 0, mce = 0, tsel = 0, pu_n = 1, wk_n = 1;
    logic [7:0] wdata = 8'h00;
    logic [2:0] sel = 3'h0;
    logic [5:0] alt = 6'h00, ext = 6'h00;
    wire  [7:0] rdata;
    wire  [5:0] po, oe, pu, lvl;
    wire        wk;
    int         err_total = 0, total_checks = 0, cyc = 0;

    sgp_port uut (.clk_i(clk_i), .srst_i(srst_i), .por_i(por_i), .port_wr_i(wr),
        .port_wdata_i(wdata), .port_rd_i(rd), .bit_set_instr_i(bset),
        .bit_clear_instr_i(bclr), .bit_sel_i(sel), .dir_load_i(dld), .work_reg_i(wdata),
        .port_rdata_o(rdata), .alt_func_i(alt), .master_clear_enable_i(mce),
        .timer_clock_source_sel_i(tsel), .pullup_en_n_i(pu_n), .wake_en_n_i(wk_n),
        .port_pins_i(lvl), .port_pins_o(po), .port_pins_oe_o(oe), .pullup_on_o(pu),
        .wake_o(wk));
    sgp_pins_model pins (.oe_i(oe), .drv_i(po), .ext_i(ext), .level_o(lvl));

    initial forever #50 clk_i = ~clk_i;

    task give_verdict;
        if (err_total == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task chk(input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    // k: 0 write, 1 read, 2 direction load, 3 bit set, 4 bit clear
    task op(input int k, input logic [7:0] v);
        @(posedge clk_i);
        wdata <= v;
        sel <= v[2:0];
        case (k)
            0: wr <= 1'b1;
            1: rd <= 1'b1;
            2: dld <= 1'b1;
            3: bset <= 1'b1;
            default: bclr <= 1'b1;
        endcase
        @(posedge clk_i);
        {wr, rd, dld, bset, bclr} <= 5'h00;
        @(negedge clk_i);
    endtask

    task t_drive;
        op(2, 8'h00);
        op(0, 8'hFF);
        chk(8'h37, {2'h0, oe});
        chk(8'h37, {2'h0, po});
        @(posedge clk_i) tsel <= 1'b1;
        @(negedge clk_i) chk(8'h33, {2'h0, oe});
        @(posedge clk_i) tsel <= 1'b0;
    endtask

    task t_read;
        op(2, 8'hFF);
        @(posedge clk_i) ext <= 6'h2A;
        repeat (3) @(posedge clk_i);
        op(1, 8'h00);
        chk(8'h2A, rdata);
        @(posedge clk_i) alt <= 6'h02;
        op(1, 8'h00);
        chk(8'h28, rdata);
        @(posedge clk_i) alt <= 6'h00;
    endtask

    // inputs are copied into latches by set/clear
    task t_rmw;
        op(3, 8'h00);
        op(2, 8'h00);
        chk(8'h23, {2'h0, po});
        repeat (3) @(posedge clk_i);
        op(4, 8'h05);
        chk(8'h03, {2'h0, po});
    endtask

    task t_resets;
        @(posedge clk_i) srst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        @(negedge clk_i) chk(8'h00, {2'h0, oe});
        op(2, 8'h00);
        chk(8'h03, {2'h0, po});
        repeat (2) @(posedge clk_i);
        op(1, 8'h00);
        chk(8'h0B, rdata);
        @(posedge clk_i) por_i <= 1'b1;
        @(posedge clk_i) por_i <= 1'b0;
        op(2, 8'h00);
        chk(8'h00, {2'h0, po});
    endtask

    task t_pull;
        @(posedge clk_i) pu_n <= 1'b0;
        @(negedge clk_i) chk(8'h0B, {2'h0, pu});
        @(posedge clk_i) {pu_n, mce} <= 2'h3;
        @(negedge clk_i) chk(8'h08, {2'h0, pu});
    endtask

    // wake pulse stands from the third edge after a pin change
    task pin_wake(input logic [5:0] v, input logic e);
        @(posedge clk_i) ext <= v;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i) chk({7'h00, e}, {7'h00, wk});
    endtask

    task t_wake;
        op(2, 8'hFF);
        @(posedge clk_i) wk_n <= 1'b0;
        repeat (4) @(posedge clk_i);
        pin_wake(6'h22, 1'b0);
        pin_wake(6'h32, 1'b0);
        pin_wake(6'h33, 1'b1);
        @(posedge clk_i) mce <= 1'b0;
        @(negedge clk_i) chk(8'h00, {2'h0, pu});
        pin_wake(6'h3B, 1'b1);
        @(posedge clk_i) wk_n <= 1'b1;
        pin_wake(6'h39, 1'b0);
    endtask

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_total++;
            give_verdict();
        end
    end

    initial begin
        repeat (2) @(posedge clk_i);
        {srst_i, por_i} <= 2'h0;
        @(negedge clk_i) chk(8'h00, {2'h0, oe});
        t_drive();
        t_read();
        t_rmw();
        t_resets();
        t_pull();
        t_wake();
        give_verdict();
    end
endmodule
